// ===== fuse_cfg_pkg.sv
// Summary of operation
// - Guard fuse bit locks oscillator calibration registers
// - Frequency select: 0x1 16 MHz, 0x2 20 MHz
// - Frequency select picks factory calibration set loaded
// - CRC source selects scan target or none
// - Pin function: GPIO, debug port, reset input
// - Preserve bit keeps EEPROM on unlocked chip erase
// - Locked device always erases EEPROM on chip erase
// - Start-up delay zero or 2^(code-1) ms
// - Application end boundary in 256-byte blocks
// - Zero application end: code to top of flash
// - Boot end boundary; zero means all boot
// - Device open only with key 0xC5
// - Locked debug port reaches only its own space
package fuse_cfg_pkg;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_OSC_CFG    = 6'h02;
  localparam logic [5:0] IDX_SYS_CFG0   = 6'h05;
  localparam logic [5:0] IDX_STARTUP    = 6'h06;
  localparam logic [5:0] IDX_APP_END    = 6'h07;
  localparam logic [5:0] IDX_BOOT_END   = 6'h08;
  localparam logic [5:0] IDX_LOCK_KEY   = 6'h0A;
  localparam logic [5:0] IDX_STATUS     = 6'h0C;

  // Field positions
  localparam int unsigned OSC_GUARD_BIT    = 7;
  localparam int unsigned FREQ_LSB         = 0;
  localparam int unsigned CRC_LSB          = 6;
  localparam int unsigned PIN_LSB          = 2;
  localparam int unsigned PRESERVE_BIT     = 0;
  localparam int unsigned SUT_LSB          = 0;
  localparam int unsigned STAT_RUN_BIT     = 0;
  localparam int unsigned STAT_LOCKED_BIT  = 1;
  localparam int unsigned STAT_FRSV_BIT    = 2;
  localparam int unsigned STAT_PRSV_BIT    = 3;

  // Implemented bits of each fuse byte, others read zero
  localparam logic [7:0] OSC_READ_MASK  = 8'h83;
  localparam logic [7:0] SYS0_READ_MASK = 8'hCD;
  localparam logic [7:0] SUT_READ_MASK  = 8'h07;

  // Shadow values before the first capture
  localparam logic [7:0] OSC_CFG_RST    = 8'h02;
  localparam logic [7:0] SYS_CFG0_RST   = 8'hC4;
  localparam logic [7:0] STARTUP_RST    = 8'h07;
  localparam logic [7:0] APP_END_RST    = 8'h00;
  localparam logic [7:0] BOOT_END_RST   = 8'h00;
  localparam logic [7:0] LOCK_KEY_RST   = 8'h00;

  // Encodings
  localparam logic [1:0] FREQ_16M       = 2'h1;
  localparam logic [1:0] FREQ_20M       = 2'h2;
  localparam logic [1:0] CRC_FULL       = 2'h0;
  localparam logic [1:0] CRC_BOOT       = 2'h1;
  localparam logic [1:0] CRC_BOOTAPP    = 2'h2;
  localparam logic [1:0] CRC_NONE       = 2'h3;
  localparam logic [1:0] PIN_GPIO       = 2'h0;
  localparam logic [1:0] PIN_DEBUG      = 2'h1;
  localparam logic [1:0] PIN_RESET      = 2'h2;
  localparam logic [7:0] OPEN_KEY       = 8'hC5;
  localparam logic [7:0] BOUNDARY_ZERO  = 8'h00;
  localparam logic [2:0] SUT_NONE       = 3'h0;

  // Start-up timing: one millisecond, rounded up to whole cycles
  localparam int unsigned MS_UNIT_NS    = 1000000;
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned MS_CYCLES     = (MS_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MS_CNT_W      = 7;

  // Loader sequence, Gray coded along the path
  typedef enum logic [1:0]
  {
    S_FILL = 2'b00,
    S_LOAD = 2'b01,
    S_WAIT = 2'b11,
    S_RUN  = 2'b10
  } load_state_e;

endpackage

// ===== fuse_sync2.sv
`timescale 1ns/10ps
module fuse_sync2 #(
  parameter int unsigned WIDTH = 8
)(
  input  wire logic             clk,    // System clock
  input  wire logic             rst_b,  // Async reset, active low
  input  wire logic             ce,     // Clock enable
  input  wire logic [WIDTH-1:0] d,      // Asynchronous input
  output logic      [WIDTH-1:0] q       // Synchronised output
);

  logic [WIDTH-1:0] meta_reg;

  // Two stages; only the second stage reads the first
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_reg <= '0;
      q        <= '0;
    end
    else if (ce)
    begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule // fuse_sync2

// ===== fuse_startup_delay.sv
`timescale 1ns/10ps
module fuse_startup_delay import fuse_cfg_pkg::*; #(
  parameter int unsigned CYCLES_PER_MS = MS_CYCLES
)(
  input  wire logic       clk,    // System clock
  input  wire logic       rst_b,  // Async reset, active low
  input  wire logic       ce,     // Clock enable
  input  wire logic       start,  // Begin delay, one-cycle pulse
  input  wire logic [2:0] code,   // Start-up select code
  output logic            done    // Delay elapsed, level
);

  localparam int unsigned PRE_W = (CYCLES_PER_MS > 1) ? $clog2(CYCLES_PER_MS) : 1;
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(CYCLES_PER_MS - 1);

  logic                run_reg;
  logic [PRE_W-1:0]    pre_reg;
  logic [MS_CNT_W-1:0] ms_reg;
  logic [MS_CNT_W-1:0] target_reg;
  logic [MS_CNT_W-1:0] ms_next;

  assign ms_next = ms_reg + 1'b1;

  // Millisecond prescaler and count; code zero finishes at once
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      run_reg    <= 1'b0;
      done       <= 1'b0;
      pre_reg    <= '0;
      ms_reg     <= '0;
      target_reg <= '0;
    end
    else if (ce)
    begin
      if (start)
      begin
        run_reg    <= (code != SUT_NONE);
        done       <= (code == SUT_NONE);
        pre_reg    <= '0;
        ms_reg     <= '0;
        target_reg <= (code == SUT_NONE) ? '0 : MS_CNT_W'(1) << (code - 3'h1);
      end
      else if (run_reg)
      begin
        if (pre_reg == PRE_LAST)
        begin
          pre_reg <= '0;
          ms_reg  <= ms_next;
          if (ms_next == target_reg)
          begin
            run_reg <= 1'b0;
            done    <= 1'b1;
          end
        end
        else
        begin
          pre_reg <= pre_reg + 1'b1;
        end
      end
    end
  end

endmodule // fuse_startup_delay

// ===== fuse_system_config_decode.sv
// The strobed register port was chosen for this implementation.
`timescale 1ns/10ps
module fuse_system_config_decode import fuse_cfg_pkg::*; #(
  parameter int unsigned CYCLES_PER_MS = MS_CYCLES,
  parameter logic [8:0]  FLASH_BLOCKS  = 9'h010,
  parameter int unsigned COARSE_W      = 7,
  parameter int unsigned TEMP_W        = 4
)(
  input  wire logic                MCLK,            // System clock
  input  wire logic                RST_B,           // Async reset, active low
  input  wire logic                CLK_EN,          // Clock enable, freezes all state
  input  wire logic [7:0]          FUSE_OSC_CFG,    // Oscillator fuse byte
  input  wire logic [7:0]          FUSE_SYS_CFG0,   // System config fuse byte
  input  wire logic [7:0]          FUSE_STARTUP,    // Start-up fuse byte
  input  wire logic [7:0]          FUSE_APP_END,    // Application end fuse byte
  input  wire logic [7:0]          FUSE_BOOT_END,   // Boot end fuse byte
  input  wire logic [7:0]          FUSE_LOCK_KEY,   // Lock key fuse byte
  input  wire logic [COARSE_W-1:0] CAL_COARSE_16M,  // Factory coarse set, 16 MHz
  input  wire logic [TEMP_W-1:0]   CAL_TEMP_16M,    // Factory temp set, 16 MHz
  input  wire logic [COARSE_W-1:0] CAL_COARSE_20M,  // Factory coarse set, 20 MHz
  input  wire logic [TEMP_W-1:0]   CAL_TEMP_20M,    // Factory temp set, 20 MHz
  input  wire logic [7:0]          ADDR,            // Register byte address
  input  wire logic [7:0]          WDATA,           // Register write data
  input  wire logic                WR,              // Write strobe
  input  wire logic                RD,              // Read strobe
  output logic      [7:0]          RDATA,           // Read data, cycle after RD
  output logic                     OSC_CAL_LOCK,    // Calibration write guard
  output logic                     OSC_SEL_16M,     // Oscillator runs at 16 MHz
  output logic                     OSC_SEL_20M,     // Oscillator runs at 20 MHz
  output logic      [COARSE_W-1:0] OSC_COARSE_CAL,  // Coarse calibration value
  output logic      [TEMP_W-1:0]   OSC_TEMP_CAL,    // Temperature calibration value
  output logic                     OSC_CAL_WRITE,   // Calibration load pulse
  output logic                     CRC_SCAN_EN,     // Memory scan enabled
  output logic      [8:0]          CRC_SCAN_LIMIT,  // Scan end, 256-byte blocks
  output logic                     PIN_FUNC_GPIO,   // Shared pin is general I/O
  output logic                     PIN_FUNC_DEBUG,  // Shared pin is debug port
  output logic                     PIN_FUNC_RESET,  // Shared pin is reset input
  input  wire logic                CHIP_ERASE,      // Chip erase request pulse
  output logic                     ERASE_FLASH,     // Flash erase pulse
  output logic                     ERASE_EEPROM,    // EEPROM erase pulse
  output logic      [8:0]          BOOT_END_BLK,    // Boot section end block
  output logic      [8:0]          APP_END_BLK,     // Application code end block
  input  wire logic [7:0]          QUERY_BLK,       // Flash block to classify
  output logic                     QUERY_BOOT,      // Block is boot section
  output logic                     QUERY_APP_CODE,  // Block is application code
  output logic                     QUERY_APP_DATA,  // Block is application data
  output logic                     DEVICE_LOCKED,   // Lock key not valid
  input  wire logic                DBG_REQ,         // Debug port access request
  input  wire logic                DBG_SYS_SPACE,   // Request targets system bus
  output logic                     DBG_GRANT,       // Access allowed
  output logic                     DBG_DENY,        // Access refused
  output logic      [7:0]          LOCK_PROG_DATA,  // Lock key to program
  output logic                     LOCK_PROG_STB,   // Lock key program pulse
  output logic                     CODE_EXEC_EN     // Start-up complete
);

  localparam int unsigned CAL_W = COARSE_W + TEMP_W;

  load_state_e         state_reg;
  logic                fill_reg;
  logic [47:0]         fuse_s;
  logic [2*CAL_W-1:0]  cal_s;
  logic [7:0]          osc_reg;
  logic [7:0]          sys0_reg;
  logic [7:0]          sut_reg;
  logic [7:0]          app_reg;
  logic [7:0]          boot_reg;
  logic [7:0]          lock_reg;
  logic                loaded_reg;
  logic                delay_done;
  logic [1:0]          freq_sel;
  logic [1:0]          crc_sel;
  logic [1:0]          pin_sel;
  logic [8:0]          boot_end_next;
  logic [8:0]          app_end_next;
  logic [8:0]          query_ext;
  logic [5:0]          bus_idx;
  logic                bus_aligned;
  logic [7:0]          rdata_next;
  logic [7:0]          status_byte;

  // Fuse bytes and calibration sets come from outside this clock domain
  fuse_sync2 #(.WIDTH(48)) u_fuse_sync
  (
    .clk   (MCLK),
    .rst_b (RST_B),
    .ce    (CLK_EN),
    .d     ({FUSE_OSC_CFG, FUSE_SYS_CFG0, FUSE_STARTUP, FUSE_APP_END, FUSE_BOOT_END, FUSE_LOCK_KEY}),
    .q     (fuse_s)
  );

  fuse_sync2 #(.WIDTH(2*CAL_W)) u_cal_sync
  (
    .clk   (MCLK),
    .rst_b (RST_B),
    .ce    (CLK_EN),
    .d     ({CAL_COARSE_16M, CAL_TEMP_16M, CAL_COARSE_20M, CAL_TEMP_20M}),
    .q     (cal_s)
  );

  // Loader sequence: fill the synchroniser, capture once, wait, run
  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      state_reg <= S_FILL;
      fill_reg  <= 1'b0;
    end
    else if (CLK_EN)
    begin
      case (state_reg)
        S_FILL:
        begin
          fill_reg <= 1'b1;
          if (fill_reg)
            state_reg <= S_LOAD;
        end
        S_LOAD:  state_reg <= S_WAIT;
        S_WAIT:
        begin
          if (delay_done)
            state_reg <= S_RUN;
        end
        S_RUN:   state_reg <= S_RUN;
        default: state_reg <= S_FILL;
      endcase
    end
  end

  // Single capture; later fuse changes wait for the next reset
  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      osc_reg    <= OSC_CFG_RST;
      sys0_reg   <= SYS_CFG0_RST;
      sut_reg    <= STARTUP_RST;
      app_reg    <= APP_END_RST;
      boot_reg   <= BOOT_END_RST;
      lock_reg   <= LOCK_KEY_RST;
      loaded_reg <= 1'b0;
    end
    else if (CLK_EN && state_reg == S_LOAD)
    begin
      {osc_reg, sys0_reg, sut_reg, app_reg, boot_reg, lock_reg} <= fuse_s;
      loaded_reg <= 1'b1;
    end
  end

  fuse_startup_delay #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_delay
  (
    .clk   (MCLK),
    .rst_b (RST_B),
    .ce    (CLK_EN),
    .start (state_reg == S_LOAD),
    .code  (fuse_s[24+SUT_LSB +: 3]),
    .done  (delay_done)
  );

  assign freq_sel = osc_reg[FREQ_LSB +: 2];
  assign crc_sel  = sys0_reg[CRC_LSB +: 2];
  assign pin_sel  = sys0_reg[PIN_LSB +: 2];

  // Zero boot end makes all flash boot; zero app end runs code to the top
  assign boot_end_next = (boot_reg == BOUNDARY_ZERO) ? FLASH_BLOCKS : {1'b0, boot_reg};
  assign app_end_next  = (boot_reg == BOUNDARY_ZERO || app_reg == BOUNDARY_ZERO)
                         ? FLASH_BLOCKS : {1'b0, app_reg};
  assign query_ext     = {1'b0, QUERY_BLK};

  // Decoded configuration, registered for clean fan-out
  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      OSC_CAL_LOCK   <= 1'b1;
      OSC_SEL_16M    <= 1'b0;
      OSC_SEL_20M    <= 1'b0;
      CRC_SCAN_EN    <= 1'b0;
      CRC_SCAN_LIMIT <= '0;
      PIN_FUNC_GPIO  <= 1'b0;
      PIN_FUNC_DEBUG <= 1'b0;
      PIN_FUNC_RESET <= 1'b0;
      BOOT_END_BLK   <= '0;
      APP_END_BLK    <= '0;
      DEVICE_LOCKED  <= 1'b1;
    end
    else if (CLK_EN && loaded_reg)
    begin
      OSC_CAL_LOCK   <= osc_reg[OSC_GUARD_BIT];
      OSC_SEL_16M    <= (freq_sel == FREQ_16M);
      OSC_SEL_20M    <= (freq_sel == FREQ_20M);
      CRC_SCAN_EN    <= (crc_sel != CRC_NONE);
      if (crc_sel == CRC_BOOT)
        CRC_SCAN_LIMIT <= boot_end_next;
      else if (crc_sel == CRC_BOOTAPP)
        CRC_SCAN_LIMIT <= app_end_next;
      else if (crc_sel == CRC_FULL)
        CRC_SCAN_LIMIT <= FLASH_BLOCKS;
      else
        CRC_SCAN_LIMIT <= '0;
      PIN_FUNC_GPIO  <= (pin_sel == PIN_GPIO);
      PIN_FUNC_DEBUG <= (pin_sel == PIN_DEBUG);
      PIN_FUNC_RESET <= (pin_sel == PIN_RESET);
      BOOT_END_BLK   <= boot_end_next;
      APP_END_BLK    <= app_end_next;
      DEVICE_LOCKED  <= (lock_reg != OPEN_KEY);
    end
  end

  // Calibration set follows the frequency choice; reserved codes take 20 MHz
  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      OSC_COARSE_CAL <= '0;
      OSC_TEMP_CAL   <= '0;
      OSC_CAL_WRITE  <= 1'b0;
    end
    else if (CLK_EN)
    begin
      OSC_CAL_WRITE <= (state_reg == S_LOAD);
      if (state_reg == S_LOAD)
      begin
        if (fuse_s[40+FREQ_LSB +: 2] == FREQ_16M)
          {OSC_COARSE_CAL, OSC_TEMP_CAL} <= cal_s[2*CAL_W-1:CAL_W];
        else
          {OSC_COARSE_CAL, OSC_TEMP_CAL} <= cal_s[CAL_W-1:0];
      end
    end
  end

  // Section of a queried block: below boot end, below app end, else data
  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      QUERY_BOOT     <= 1'b0;
      QUERY_APP_CODE <= 1'b0;
      QUERY_APP_DATA <= 1'b0;
    end
    else if (CLK_EN)
    begin
      QUERY_BOOT     <= loaded_reg && (query_ext < boot_end_next);
      QUERY_APP_CODE <= loaded_reg && (query_ext >= boot_end_next) && (query_ext < app_end_next);
      QUERY_APP_DATA <= loaded_reg && (query_ext >= app_end_next);
    end
  end

  // Chip erase; a locked device never keeps its EEPROM
  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      ERASE_FLASH  <= 1'b0;
      ERASE_EEPROM <= 1'b0;
    end
    else if (CLK_EN)
    begin
      ERASE_FLASH  <= CHIP_ERASE && loaded_reg;
      ERASE_EEPROM <= CHIP_ERASE && loaded_reg
                      && (DEVICE_LOCKED || !sys0_reg[PRESERVE_BIT]);
    end
  end

  // Debug access gate; before the first capture the device counts as locked
  assign DBG_GRANT = DBG_REQ && (!DBG_SYS_SPACE || !DEVICE_LOCKED);
  assign DBG_DENY  = DBG_REQ && DBG_SYS_SPACE && DEVICE_LOCKED;

  assign CODE_EXEC_EN = (state_reg == S_RUN);

  // Register decode; misaligned or unmapped reads return zero
  assign bus_idx     = ADDR[7:2];
  assign bus_aligned = (ADDR[1:0] == 2'h0);

  always_comb
  begin
    status_byte = 8'h00;
    status_byte[STAT_RUN_BIT]    = CODE_EXEC_EN;
    status_byte[STAT_LOCKED_BIT] = DEVICE_LOCKED;
    status_byte[STAT_FRSV_BIT]   = loaded_reg && (freq_sel != FREQ_16M) && (freq_sel != FREQ_20M);
    status_byte[STAT_PRSV_BIT]   = loaded_reg && (pin_sel == 2'h3);
  end

  always_comb
  begin
    rdata_next = 8'h00;
    if (!bus_aligned)
      rdata_next = 8'h00;
    else if (bus_idx == IDX_OSC_CFG)
      rdata_next = osc_reg & OSC_READ_MASK;
    else if (bus_idx == IDX_SYS_CFG0)
      rdata_next = sys0_reg & SYS0_READ_MASK;
    else if (bus_idx == IDX_STARTUP)
      rdata_next = sut_reg & SUT_READ_MASK;
    else if (bus_idx == IDX_APP_END)
      rdata_next = app_reg;
    else if (bus_idx == IDX_BOOT_END)
      rdata_next = boot_reg;
    else if (bus_idx == IDX_LOCK_KEY)
      rdata_next = lock_reg;
    else if (bus_idx == IDX_STATUS)
      rdata_next = status_byte;
  end

  // Read data holds only in the cycle after the strobe
  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
      RDATA <= 8'h00;
    else if (CLK_EN)
      RDATA <= RD ? rdata_next : 8'h00;
  end

  // Lock key write requests fuse programming; decode changes after reset
  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      LOCK_PROG_DATA <= 8'h00;
      LOCK_PROG_STB  <= 1'b0;
    end
    else if (CLK_EN)
    begin
      LOCK_PROG_STB <= WR && bus_aligned && (bus_idx == IDX_LOCK_KEY);
      if (WR && bus_aligned && bus_idx == IDX_LOCK_KEY)
        LOCK_PROG_DATA <= WDATA;
    end
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_B);

  property p_cal_lock;
    CLK_EN && loaded_reg |=> !CLK_EN || (OSC_CAL_LOCK == $past(osc_reg[OSC_GUARD_BIT]));
  endproperty
  a_cal_lock: assert property (p_cal_lock) else $error("guard bit not copied");

  property p_freq_sel;
    CLK_EN && loaded_reg |=> !CLK_EN || (OSC_SEL_20M == ($past(freq_sel) == FREQ_20M)
                                         && !(OSC_SEL_16M && OSC_SEL_20M));
  endproperty
  a_freq_sel: assert property (p_freq_sel) else $error("frequency select wrong");

  property p_cal_set;
    CLK_EN && state_reg == S_LOAD && fuse_s[41:40] == FREQ_16M
      |=> !CLK_EN || (OSC_CAL_WRITE && OSC_COARSE_CAL == $past(cal_s[2*CAL_W-1:CAL_W+TEMP_W]));
  endproperty
  a_cal_set: assert property (p_cal_set) else $error("16 MHz calibration set not loaded");

  property p_crc_none;
    CLK_EN && loaded_reg && crc_sel == CRC_NONE |=> !CLK_EN || !CRC_SCAN_EN;
  endproperty
  a_crc_none: assert property (p_crc_none) else $error("scan enabled with no source");

  property p_pin_onehot;
    $onehot0({PIN_FUNC_GPIO, PIN_FUNC_DEBUG, PIN_FUNC_RESET});
  endproperty
  a_pin_onehot: assert property (p_pin_onehot) else $error("pin function not exclusive");

  property p_eeprom_keep;
    CLK_EN && CHIP_ERASE && loaded_reg && sys0_reg[PRESERVE_BIT] && !DEVICE_LOCKED
      |=> !CLK_EN || (ERASE_FLASH && !ERASE_EEPROM);
  endproperty
  a_eeprom_keep: assert property (p_eeprom_keep) else $error("preserved EEPROM erased");

  property p_eeprom_locked;
    CLK_EN && CHIP_ERASE && loaded_reg && DEVICE_LOCKED |=> !CLK_EN || ERASE_EEPROM;
  endproperty
  a_eeprom_locked: assert property (p_eeprom_locked) else $error("locked erase kept EEPROM");

  property p_sut_zero;
    CLK_EN && state_reg == S_LOAD && fuse_s[24+SUT_LSB +: 3] == SUT_NONE
      ##1 CLK_EN [*2] |-> ##1 CODE_EXEC_EN;
  endproperty
  a_sut_zero: assert property (p_sut_zero) else $error("zero start-up delay not immediate");

  property p_boot_zero;
    CLK_EN && loaded_reg && boot_reg == BOUNDARY_ZERO
      |=> !CLK_EN || (BOOT_END_BLK == FLASH_BLOCKS && APP_END_BLK == FLASH_BLOCKS);
  endproperty
  a_boot_zero: assert property (p_boot_zero) else $error("zero boot end not whole flash");

  property p_lock_key;
    CLK_EN && loaded_reg |=> !CLK_EN || (DEVICE_LOCKED == ($past(lock_reg) != OPEN_KEY));
  endproperty
  a_lock_key: assert property (p_lock_key) else $error("lock state mismatches key");

  property p_dbg_deny;
    DBG_REQ && DBG_SYS_SPACE && DEVICE_LOCKED |-> DBG_DENY && !DBG_GRANT;
  endproperty
  a_dbg_deny: assert property (p_dbg_deny) else $error("locked debug got system bus");

  property p_held;
    state_reg == S_RUN |=> $stable(lock_reg) && $stable(sys0_reg) && $stable(osc_reg);
  endproperty
  a_held: assert property (p_held) else $error("fuse shadow changed after capture");

  c_run:     cover property (state_reg == S_WAIT ##1 state_reg == S_RUN);
  c_deny:    cover property (DBG_DENY);
  c_keep:    cover property (ERASE_FLASH && !ERASE_EEPROM);
  c_sel_16m: cover property (OSC_SEL_16M && OSC_CAL_WRITE);

endmodule // fuse_system_config_decode

// ===== fuse_system_config_decode_tb.sv
`timescale 1ns/10ps
module fuse_system_config_decode_tb import fuse_cfg_pkg::*;;
  // One row per fuse image: inputs, packed flags, scan limit, query block and result
  typedef struct packed
  {
    logic [7:0] osc, sys0, app, boot, lock, fl, qb;
    logic [8:0] lim;
    logic [2:0] qe;
  } row_s;
  // Flags: cal lock, sel16, sel20, crc en, gpio, debug, reset pin, locked
  row_s rows [4] = '{'{8'h81, 8'h05, 8'h00, 8'h04, 8'hC5, 8'hD4, 8'h0F, 9'h010, 3'b010},
                     '{8'h02, 8'h48, 8'h08, 8'h04, 8'h00, 8'h33, 8'h08, 9'h004, 3'b001},
                     '{8'h03, 8'h80, 8'h0A, 8'h02, 8'hC4, 8'h19, 8'h01, 9'h00A, 3'b100},
                     '{8'h82, 8'hCC, 8'h00, 8'h00, 8'hC5, 8'hA0, 8'h05, 9'h000, 3'b100}};
  row_s       r;
  logic       MCLK = 1'b0, RST_B = 1'b0, CLK_EN = 1'b1, WR = 1'b0, RD = 1'b0;
  logic       CHIP_ERASE = 1'b0, DBG_REQ = 1'b0, DBG_SYS_SPACE = 1'b0;
  logic [7:0] FUSE_OSC_CFG = 8'h00, FUSE_SYS_CFG0 = 8'h00, FUSE_STARTUP = 8'h00, FUSE_APP_END = 8'h00;
  logic [7:0] FUSE_BOOT_END = 8'h00, FUSE_LOCK_KEY = 8'h00, ADDR = 8'h00, WDATA = 8'h00, QUERY_BLK = 8'h00;
  logic [6:0] CAL_COARSE_16M = 7'h15, CAL_COARSE_20M = 7'h2A, OSC_COARSE_CAL;
  logic [3:0] CAL_TEMP_16M = 4'h3, CAL_TEMP_20M = 4'hC, OSC_TEMP_CAL;
  logic [7:0] RDATA, LOCK_PROG_DATA, rv;
  logic [8:0] CRC_SCAN_LIMIT, BOOT_END_BLK, APP_END_BLK;
  logic       OSC_CAL_LOCK, OSC_SEL_16M, OSC_SEL_20M, OSC_CAL_WRITE, CRC_SCAN_EN, PIN_FUNC_GPIO;
  logic       PIN_FUNC_DEBUG, PIN_FUNC_RESET, ERASE_FLASH, ERASE_EEPROM, QUERY_BOOT, QUERY_APP_CODE;
  logic       QUERY_APP_DATA, DEVICE_LOCKED, DBG_GRANT, DBG_DENY, LOCK_PROG_STB, CODE_EXEC_EN;
  int         errors = 0, samples_checked = 0, cyc = 0;

  // Short millisecond keeps the start-up delay test brief
  fuse_system_config_decode #(.CYCLES_PER_MS(4)) dut (.*);

  // 40 MHz clock
  always #12.5 MCLK = ~MCLK;

  // Hang guard, well above the roughly 130 cycles the run needs
  always @(posedge MCLK)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      errors++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checked %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Fuses must already be set; decode is valid four edges after release
  task automatic rst();
    @(posedge MCLK);
    RST_B <= 1'b0;
    repeat (8) @(posedge MCLK);
    RST_B <= 1'b1;
  endtask

  // One-cycle strobe; read data sampled in the cycle after
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge MCLK);
    WR <= w;
    RD <= !w;
    ADDR <= a;
    WDATA <= d;
    @(posedge MCLK);
    WR <= 1'b0;
    RD <= 1'b0;
    #1 rv = RDATA;
  endtask

  task automatic ers();
    @(posedge MCLK);
    CHIP_ERASE <= 1'b1;
    @(posedge MCLK);
    CHIP_ERASE <= 1'b0;
    #1;
  endtask

  // Table of fuse images, then lock, refusal and start-up cases
  initial
  begin
    #30 chk({OSC_CAL_LOCK, DEVICE_LOCKED, RDATA}, 16'h0300);
    foreach (rows[i])
    begin
      @(posedge MCLK);
      r = rows[i];
      FUSE_OSC_CFG <= r.osc;
      FUSE_SYS_CFG0 <= r.sys0;
      FUSE_APP_END <= r.app;
      FUSE_BOOT_END <= r.boot;
      FUSE_LOCK_KEY <= r.lock;
      QUERY_BLK <= r.qb;
      DBG_REQ <= 1'b1;
      DBG_SYS_SPACE <= 1'b1;
      rst();
      repeat (7) @(posedge MCLK);
      #1;
      chk({OSC_CAL_LOCK, OSC_SEL_16M, OSC_SEL_20M, CRC_SCAN_EN, PIN_FUNC_GPIO, PIN_FUNC_DEBUG,
           PIN_FUNC_RESET, DEVICE_LOCKED}, r.fl);
      chk(CRC_SCAN_LIMIT, r.lim);
      chk({OSC_COARSE_CAL, OSC_TEMP_CAL}, r.fl[6] ? 11'h153 : 11'h2AC);
      chk({QUERY_BOOT, QUERY_APP_CODE, QUERY_APP_DATA}, r.qe);
      chk(BOOT_END_BLK, r.boot == 8'h00 ? 9'h010 : {1'b0, r.boot});
      chk(APP_END_BLK, (r.boot == 8'h00 || r.app == 8'h00) ? 9'h010 : {1'b0, r.app});
      chk({DBG_GRANT, DBG_DENY, CODE_EXEC_EN}, {!r.fl[0], r.fl[0], 1'b1});
      bus(1'b0, 8'h14, 8'h00);
      chk(rv, r.sys0 & SYS0_READ_MASK);
      ers();
      chk({ERASE_FLASH, ERASE_EEPROM}, {1'b1, r.fl[0] | !r.sys0[0]});
    end
    // Key write only requests programming; decode keeps the captured key
    bus(1'b1, 8'h28, 8'h5A);
    chk({LOCK_PROG_STB, LOCK_PROG_DATA}, 16'h015A);
    @(posedge MCLK);
    FUSE_LOCK_KEY <= 8'h00;
    bus(1'b0, 8'h28, 8'h00);
    chk({DEVICE_LOCKED, rv}, 16'h00C5);
    bus(1'b1, 8'h14, 8'h00);
    bus(1'b0, 8'h14, 8'h00);
    chk(rv, 8'hCC);
    bus(1'b0, 8'h04, 8'h00);
    chk(rv, 8'h00);
    bus(1'b0, 8'h15, 8'h00);
    chk(rv, 8'h00);
    // Start-up code 2: two short milliseconds after the capture edge
    @(posedge MCLK);
    FUSE_STARTUP <= 8'h02;
    FUSE_SYS_CFG0 <= 8'h05;
    rst();
    #1 chk({OSC_CAL_LOCK, DEVICE_LOCKED, CODE_EXEC_EN, OSC_SEL_20M}, 4'hC);
    repeat (3) @(posedge MCLK);
    #1 chk(OSC_CAL_WRITE, 1'b1);
    repeat (8) @(posedge MCLK);
    #1 chk(CODE_EXEC_EN, 1'b0);
    @(posedge MCLK);
    #1 chk({CODE_EXEC_EN, DEVICE_LOCKED, DBG_DENY, OSC_CAL_WRITE}, 4'hE);
    bus(1'b0, 8'h30, 8'h00);
    chk(rv, 8'h03);
    bus(1'b0, 8'h08, 8'h00);
    chk(rv, 8'h82);
    bus(1'b0, 8'h18, 8'h00);
    chk(rv, 8'h02);
    // Frozen clock enable must swallow an erase request
    @(posedge MCLK);
    CLK_EN <= 1'b0;
    ers();
    chk({ERASE_FLASH, ERASE_EEPROM}, 2'b00);
    @(posedge MCLK);
    CLK_EN <= 1'b1;
    ers();
    chk({ERASE_FLASH, ERASE_EEPROM}, 2'b11);
    test_done();
  end
endmodule // fuse_system_config_decode_tb
